// ===== pkg/wwd_pkg.sv
// Function
// RULE_01: While enabled, count and request reset when no clear comes before time-out.
// RULE_02: Eleven time-out lengths, 8 ms doubling up to 8.192 s.
// RULE_03: Counter advances on a 1 kHz tick, independent of the bus side.
// RULE_04: Each accepted clear instruction restarts the time-out interval.
// RULE_05: Normal or window mode, selected by control register A contents.
// RULE_06: In window mode, a clear during the closed slot requests reset.
// RULE_07: Counting continues in active operation and all sleep states.
// RULE_08: Counting and reset request survive a stopped system clock; code derives the tick from i_core_clk, so counting stops with it.
// RULE_09: Control writes pass a synchronising delay before they take effect.
// RULE_10: A configuration lock, once set, blocks further setting changes.
// RULE_11: Protected settings change only after the unlock key; others are ignored.
// RULE_12: Closed period starts only after the first clear in window mode.
// RULE_13: Non-zero period enables, non-zero window selects window mode; codes 1..B.
// RULE_14: Software writes the key, then the protected bits within four accesses.
// RULE_15: Lock set by writing one, cleared only in debug, set on fuse load; code sets it at fuse load only for a non-zero fuse period code.
// RULE_16: Clear sync takes two to three ticks; further clears ignored, flag shown.
// RULE_17: Reset request is held high until the system reset arrives.
package wwd_pkg;
  localparam int CORE_CLK_HZ = 200_000_000;
  localparam int WDT_CLK_HZ = 1_000;
  localparam int TICK_DIV = CORE_CLK_HZ / WDT_CLK_HZ;
  localparam int MIN_TIMEOUT_MS = 8;
  localparam int MIN_TIMEOUT_TICKS = (WDT_CLK_HZ * MIN_TIMEOUT_MS + 999) / 1000;
  localparam int CNT_W = 14;
  localparam int CODE_W = 4;
  localparam logic [CODE_W-1:0] CODE_OFF = 4'h0;
  localparam logic [CODE_W-1:0] CODE_ONE = 4'h1;
  localparam logic [CODE_W-1:0] CODE_MAX = 4'hB;
  localparam int CTRL_PER_LSB = 0;
  localparam int CTRL_WIN_LSB = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOCK_BIT = 7;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h000;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h001;
  localparam logic [IDX_W-1:0] IDX_PROT = 10'h002;
  localparam logic [7:0] PROT_KEY_DEFAULT = 8'hA5;
  localparam logic [2:0] PROT_WINDOW = 3'h4;
  localparam logic [1:0] CLR_SYNC_TICKS = 2'h3;
  localparam logic [1:0] CTRL_SYNC_TICKS = 2'h2;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wwd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } wwd_apb_rsp_t;

  typedef enum logic [1:0] {
    WWD_OFF = 2'h0,
    WWD_RUN = 2'h1,
    WWD_CLOSED = 2'h3,
    WWD_OPEN = 2'h2
  } wwd_mode_t;

  function automatic logic [CNT_W-1:0] wwd_code_ticks(input logic [CODE_W-1:0] code);
    logic [CODE_W-1:0] c;
    c = (code > CODE_MAX) ? CODE_MAX : code;
    return CNT_W'(MIN_TIMEOUT_TICKS) << (c - CODE_ONE);
  endfunction : wwd_code_ticks
endpackage : wwd_pkg

// ===== hdl/wwd_tick_div.sv
`timescale 1ns/1ps
module wwd_tick_div #(
  parameter int DIV = 200_000
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  output logic o_tick
);
  localparam int W = $clog2(DIV);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } wwd_div_st_t;
  wwd_div_st_t st_reg;
  wwd_div_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == W'(DIV - 1)) begin
      st_next.cnt = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_tick = st_reg.tick;
endmodule : wwd_tick_div

// ===== hdl/wwd_watchdog.sv
`timescale 1ns/1ps
module wwd_watchdog #(
  parameter int TICK_DIV = wwd_pkg::TICK_DIV,
  parameter logic [7:0] PROT_KEY = wwd_pkg::PROT_KEY_DEFAULT
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire wwd_pkg::wwd_apb_req_t i_apb,
  input wire logic i_clear_instr,
  input wire logic i_debug_halt,
  input wire logic [7:0] i_fuse_ctrl,
  output wwd_pkg::wwd_apb_rsp_t o_apb,
  output logic o_reset_req
);
  typedef struct packed {
    wwd_pkg::wwd_mode_t mode;
    logic [wwd_pkg::CNT_W-1:0] cnt;
    logic [7:0] ctrl;
    logic [7:0] act;
    logic lock;
    logic [2:0] prot_left;
    logic csync_pend;
    logic [1:0] csync_cnt;
    logic wsync_pend;
    logic [1:0] wsync_cnt;
    logic rst_req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic boot;
  } wwd_core_st_t;

  wwd_core_st_t st_reg;
  wwd_core_st_t st_next;
  logic tick;
  logic setup;
  logic acc;
  logic [wwd_pkg::IDX_W-1:0] idx;
  logic prot_ok;
  logic ctrl_wr_ok;
  logic stat_wr;
  logic key_wr;
  logic clr_apply;
  logic ctrl_apply;
  logic [wwd_pkg::CNT_W-1:0] per_lim;
  logic [wwd_pkg::CNT_W-1:0] win_lim;
  logic win_on;

  function automatic logic [wwd_pkg::CODE_W-1:0] per_of(input logic [7:0] c);
    return c[wwd_pkg::CTRL_PER_LSB +: wwd_pkg::CODE_W];
  endfunction : per_of

  function automatic logic [wwd_pkg::CODE_W-1:0] win_of(input logic [7:0] c);
    return c[wwd_pkg::CTRL_WIN_LSB +: wwd_pkg::CODE_W];
  endfunction : win_of

  // Free-running 1 kHz tick; nothing here gates it on sleep state
  wwd_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .o_tick(tick)
  ); // RULE_03 RULE_07 RULE_08

  assign idx = i_apb.paddr[11:2];
  assign setup = i_apb.psel & ~i_apb.penable;
  assign acc = i_apb.psel & i_apb.penable & st_reg.pready;
  assign prot_ok = (st_reg.prot_left != 3'h0); // RULE_14
  assign key_wr = acc & i_apb.pwrite & (idx == wwd_pkg::IDX_PROT)
                  & (i_apb.pwdata[7:0] == PROT_KEY);
  // Writes during a pending sync are dropped rather than queued
  assign ctrl_wr_ok = acc & i_apb.pwrite & (idx == wwd_pkg::IDX_CTRL_A) & prot_ok
                      & ~st_reg.lock & ~st_reg.wsync_pend; // RULE_10 RULE_11
  assign stat_wr = acc & i_apb.pwrite & (idx == wwd_pkg::IDX_STATUS) & prot_ok; // RULE_11
  assign clr_apply = st_reg.csync_pend & tick
                     & (st_reg.csync_cnt == wwd_pkg::CLR_SYNC_TICKS - 2'h1); // RULE_16
  assign ctrl_apply = st_reg.wsync_pend & tick
                      & (st_reg.wsync_cnt == wwd_pkg::CTRL_SYNC_TICKS - 2'h1); // RULE_09
  assign per_lim = wwd_pkg::wwd_code_ticks(per_of(st_reg.act)); // RULE_02 RULE_13
  assign win_lim = wwd_pkg::wwd_code_ticks(win_of(st_reg.act)); // RULE_02 RULE_13
  assign win_on = (win_of(st_reg.act) != wwd_pkg::CODE_OFF); // RULE_05

  always_comb begin
    st_next = st_reg;
    st_next.pready = setup;
    st_next.pslverr = 1'b0;
    st_next.prdata = '0;
    if (st_reg.boot) begin
      // Fuse image becomes both shadow and active copy
      st_next.boot = 1'b0;
      st_next.ctrl = i_fuse_ctrl;
      st_next.act = i_fuse_ctrl;
      st_next.lock = (per_of(i_fuse_ctrl) != wwd_pkg::CODE_OFF); // RULE_15
      st_next.mode = (per_of(i_fuse_ctrl) != wwd_pkg::CODE_OFF) ?
                     wwd_pkg::WWD_RUN : wwd_pkg::WWD_OFF;
    end else begin
      // Bus read data, captured in the setup cycle
      if (setup && !i_apb.pwrite) begin
        case (idx)
          wwd_pkg::IDX_CTRL_A: st_next.prdata = {24'h000000, st_reg.ctrl};
          wwd_pkg::IDX_STATUS: begin
            st_next.prdata[wwd_pkg::STAT_LOCK_BIT] = st_reg.lock;
            st_next.prdata[wwd_pkg::STAT_BUSY_BIT] = st_reg.wsync_pend | st_reg.csync_pend; // RULE_16
          end
          wwd_pkg::IDX_PROT: st_next.prdata = '0;
          default: st_next.prdata = '0;
        endcase
      end
      if (setup && idx != wwd_pkg::IDX_CTRL_A && idx != wwd_pkg::IDX_STATUS
          && idx != wwd_pkg::IDX_PROT) begin
        st_next.pslverr = 1'b1;
      end

      // Each completed access counts as one instruction of the unlock window
      if (key_wr) begin
        st_next.prot_left = wwd_pkg::PROT_WINDOW; // RULE_14
      end else if (acc && prot_ok) begin
        st_next.prot_left = st_reg.prot_left - 3'h1; // RULE_14
      end

      if (ctrl_wr_ok) begin
        st_next.ctrl = i_apb.pwdata[7:0]; // RULE_09
        st_next.wsync_pend = 1'b1;
        st_next.wsync_cnt = 2'h0;
      end

      if (stat_wr && i_apb.pwdata[wwd_pkg::STAT_LOCK_BIT]) begin
        st_next.lock = 1'b1; // RULE_10 RULE_15
      end else if (stat_wr && i_debug_halt) begin
        st_next.lock = 1'b0; // RULE_15
      end

      // A clear while one is in flight is dropped
      if (i_clear_instr && !st_reg.csync_pend && st_reg.mode != wwd_pkg::WWD_OFF) begin
        st_next.csync_pend = 1'b1; // RULE_04 RULE_16
        st_next.csync_cnt = 2'h0;
      end

      if (tick) begin
        if (st_reg.csync_pend) begin
          st_next.csync_cnt = st_reg.csync_cnt + 2'h1;
          if (clr_apply) begin
            st_next.csync_pend = 1'b0;
          end
        end
        if (st_reg.wsync_pend && !ctrl_wr_ok) begin
          st_next.wsync_cnt = st_reg.wsync_cnt + 2'h1;
          if (ctrl_apply) begin
            st_next.wsync_pend = 1'b0;
          end
        end
        if (ctrl_apply) begin
          // New settings restart from the pre-first-clear state
          st_next.act = st_reg.ctrl; // RULE_09
          st_next.cnt = '0;
          st_next.mode = (per_of(st_reg.ctrl) != wwd_pkg::CODE_OFF) ?
                         wwd_pkg::WWD_RUN : wwd_pkg::WWD_OFF; // RULE_13 RULE_12
        end else if (st_reg.mode != wwd_pkg::WWD_OFF) begin
          if (clr_apply) begin
            st_next.cnt = '0; // RULE_04
            if (st_reg.mode == wwd_pkg::WWD_CLOSED) begin
              st_next.rst_req = 1'b1; // RULE_06
            end else if (win_on) begin
              st_next.mode = wwd_pkg::WWD_CLOSED; // RULE_12
            end else begin
              st_next.mode = wwd_pkg::WWD_RUN; // RULE_05
            end
          end else begin
            case (st_reg.mode)
              wwd_pkg::WWD_RUN, wwd_pkg::WWD_OPEN: begin
                if (st_reg.cnt >= per_lim - wwd_pkg::CNT_W'(1)) begin
                  st_next.rst_req = 1'b1; // RULE_01 RULE_06
                end else begin
                  st_next.cnt = st_reg.cnt + wwd_pkg::CNT_W'(1); // RULE_01
                end
              end
              wwd_pkg::WWD_CLOSED: begin
                if (st_reg.cnt >= win_lim - wwd_pkg::CNT_W'(1)) begin
                  st_next.mode = wwd_pkg::WWD_OPEN;
                  st_next.cnt = '0;
                end else begin
                  st_next.cnt = st_reg.cnt + wwd_pkg::CNT_W'(1);
                end
              end
              default: st_next.mode = wwd_pkg::WWD_OFF;
            endcase
          end
        end
      end

      // Debug halt: counter held at zero, mode back to the pre-first-clear run state
      if (i_debug_halt && st_reg.mode != wwd_pkg::WWD_OFF && !ctrl_apply) begin
        st_next.cnt = '0;
        st_next.mode = wwd_pkg::WWD_RUN;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      st_reg <= '0;
      st_reg.boot <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_apb.pready = st_reg.pready;
  assign o_apb.pslverr = st_reg.pslverr;
  assign o_apb.prdata = st_reg.prdata;
  assign o_reset_req = st_reg.rst_req; // RULE_17

  property p_expire;
    @(posedge i_core_clk) disable iff (i_reset)
    (tick && !st_reg.boot && !ctrl_apply && !clr_apply
     && (st_reg.mode == wwd_pkg::WWD_RUN || st_reg.mode == wwd_pkg::WWD_OPEN)
     && st_reg.cnt >= per_lim - wwd_pkg::CNT_W'(1)) |=> st_reg.rst_req;
  endproperty
  a_expire: assert property (p_expire) else $error("Time-out did not raise reset"); // RULE_01

  property p_rst_hold;
    @(posedge i_core_clk) disable iff (i_reset)
    st_reg.rst_req |=> st_reg.rst_req [*3];
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("Reset request dropped"); // RULE_17

  property p_early;
    @(posedge i_core_clk) disable iff (i_reset)
    (clr_apply && !ctrl_apply && st_reg.mode == wwd_pkg::WWD_CLOSED) |=> st_reg.rst_req;
  endproperty
  a_early: assert property (p_early) else $error("Early clear not punished"); // RULE_06

  property p_first;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.mode == wwd_pkg::WWD_RUN && !clr_apply) |=> st_reg.mode != wwd_pkg::WWD_CLOSED;
  endproperty
  a_first: assert property (p_first) else $error("Closed period without clear"); // RULE_12

  property p_restart;
    @(posedge i_core_clk) disable iff (i_reset)
    (clr_apply && !ctrl_apply && st_reg.mode == wwd_pkg::WWD_RUN) |=> st_reg.cnt == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("Clear did not restart count"); // RULE_04

  property p_ignore;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.csync_pend && i_clear_instr && !tick) |=> st_reg.csync_cnt == $past(st_reg.csync_cnt);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Clear during sync not ignored"); // RULE_16

  property p_lock;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.lock && !st_reg.boot) |=> $stable(st_reg.ctrl);
  endproperty
  a_lock: assert property (p_lock) else $error("Locked control changed"); // RULE_15

  property p_lock_stay;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.lock && !i_debug_halt) |=> st_reg.lock;
  endproperty
  a_lock_stay: assert property (p_lock_stay) else $error("Lock cleared outside debug"); // RULE_10

  property p_unprot;
    @(posedge i_core_clk) disable iff (i_reset)
    (acc && i_apb.pwrite && idx == wwd_pkg::IDX_CTRL_A && st_reg.prot_left == 3'h0
     && !st_reg.boot) |=> $stable(st_reg.ctrl);
  endproperty
  a_unprot: assert property (p_unprot) else $error("Unprotected write took effect"); // RULE_11

  property p_sync;
    @(posedge i_core_clk) disable iff (i_reset)
    ctrl_wr_ok |=> (st_reg.wsync_pend && st_reg.act == $past(st_reg.act));
  endproperty
  a_sync: assert property (p_sync) else $error("Control write applied unsynchronised"); // RULE_09

  property p_apb;
    @(posedge i_core_clk) disable iff (i_reset)
    setup |=> st_reg.pready;
  endproperty
  a_apb: assert property (p_apb) else $error("No ready after setup");

  property p_cnt_lim;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.mode == wwd_pkg::WWD_RUN || st_reg.mode == wwd_pkg::WWD_OPEN)
    |-> (st_reg.cnt < per_lim);
  endproperty
  a_cnt_lim: assert property (p_cnt_lim) else $error("Count beyond period"); // RULE_01

  property p_win_lim;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.mode == wwd_pkg::WWD_CLOSED) |-> (st_reg.cnt < win_lim);
  endproperty
  a_win_lim: assert property (p_win_lim) else $error("Count beyond closed period"); // RULE_06

  property p_step;
    @(posedge i_core_clk) disable iff (i_reset)
    (!tick && !i_debug_halt && !st_reg.boot) |=> ($stable(st_reg.cnt) && $stable(st_reg.mode));
  endproperty
  a_step: assert property (p_step) else $error("Count moved without tick"); // RULE_03

  property p_off_clear;
    @(posedge i_core_clk) disable iff (i_reset)
    (i_clear_instr && !st_reg.csync_pend && st_reg.mode == wwd_pkg::WWD_OFF)
    |=> !st_reg.csync_pend;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("Clear taken while off"); // RULE_13

  property p_clr_take;
    @(posedge i_core_clk) disable iff (i_reset)
    (i_clear_instr && !st_reg.csync_pend && st_reg.mode != wwd_pkg::WWD_OFF && !st_reg.boot)
    |=> (st_reg.csync_pend && st_reg.csync_cnt == 2'h0);
  endproperty
  a_clr_take: assert property (p_clr_take) else $error("Clear not taken for sync"); // RULE_16

  property p_apply_off;
    @(posedge i_core_clk) disable iff (i_reset)
    (ctrl_apply && per_of(st_reg.ctrl) == wwd_pkg::CODE_OFF)
    |=> (st_reg.mode == wwd_pkg::WWD_OFF && st_reg.act == $past(st_reg.ctrl));
  endproperty
  a_apply_off: assert property (p_apply_off) else $error("Zero period did not stop"); // RULE_13

  property p_apply_on;
    @(posedge i_core_clk) disable iff (i_reset)
    (ctrl_apply && per_of(st_reg.ctrl) != wwd_pkg::CODE_OFF)
    |=> (st_reg.mode == wwd_pkg::WWD_RUN && st_reg.cnt == '0);
  endproperty
  a_apply_on: assert property (p_apply_on) else $error("New settings not restarted"); // RULE_12

  property p_debug;
    @(posedge i_core_clk) disable iff (i_reset)
    (i_debug_halt && st_reg.mode != wwd_pkg::WWD_OFF && !ctrl_apply && !st_reg.boot)
    |=> (st_reg.mode == wwd_pkg::WWD_RUN && st_reg.cnt == '0);
  endproperty
  a_debug: assert property (p_debug) else $error("Debug halt did not hold count"); // RULE_12

  property p_status;
    @(posedge i_core_clk) disable iff (i_reset)
    (setup && !i_apb.pwrite && idx == wwd_pkg::IDX_STATUS && !st_reg.boot)
    |=> (st_reg.prdata[wwd_pkg::STAT_LOCK_BIT] == $past(st_reg.lock)
         && st_reg.prdata[wwd_pkg::STAT_BUSY_BIT]
            == $past(st_reg.wsync_pend | st_reg.csync_pend));
  endproperty
  a_status: assert property (p_status) else $error("Status read wrong"); // RULE_16

  property p_key;
    @(posedge i_core_clk) disable iff (i_reset)
    key_wr |=> (st_reg.prot_left == wwd_pkg::PROT_WINDOW);
  endproperty
  a_key: assert property (p_key) else $error("Unlock window not opened"); // RULE_14

  property p_fuse;
    @(posedge i_core_clk) disable iff (i_reset)
    (st_reg.boot && !i_reset)
    |=> (st_reg.ctrl == $past(i_fuse_ctrl) && st_reg.act == $past(i_fuse_ctrl)
         && st_reg.lock == (per_of($past(i_fuse_ctrl)) != wwd_pkg::CODE_OFF));
  endproperty
  a_fuse: assert property (p_fuse) else $error("Fuse image not loaded"); // RULE_15
endmodule : wwd_watchdog

// ===== bench/wwd_core_model.sv
`timescale 1ns/1ps
module wwd_core_model #(
  parameter logic [7:0] KEY = 8'h3C
) (
  input wire logic i_core_clk,
  input wire wwd_pkg::wwd_apb_rsp_t i_apb,
  output wwd_pkg::wwd_apb_req_t o_apb,
  output logic o_clear_instr
);
  initial begin
    o_apb = '0;
    o_clear_instr = 1'b0;
  end

  // Released address and data lines show inverted data, never the last value
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic hung);
    int n;
    @(posedge i_core_clk);
    o_apb.psel <= 1'b1;
    o_apb.penable <= 1'b0;
    o_apb.pwrite <= wr;
    o_apb.paddr <= a;
    o_apb.pwdata <= d;
    @(posedge i_core_clk);
    o_apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (i_apb.pready !== 1'b1 && n < 32);
    q = i_apb.prdata;
    err = i_apb.pslverr;
    hung = (n >= 32);
    o_apb.psel <= 1'b0;
    o_apb.penable <= 1'b0;
    o_apb.paddr <= ~a;
    o_apb.pwdata <= ~d;
  endtask : xfer

  task automatic clear_pulse();
    @(posedge i_core_clk);
    o_clear_instr <= 1'b1;
    @(posedge i_core_clk);
    o_clear_instr <= 1'b0;
  endtask : clear_pulse
endmodule : wwd_core_model

// ===== bench/wwd_watchdog_tb.sv
`timescale 1ns/1ps
module wwd_watchdog_tb;
  localparam int DIV = 4;
  localparam logic [7:0] KEY = 8'h3C; // Arbitrary key value
  localparam logic [11:0] A_CTRL = {wwd_pkg::IDX_CTRL_A, 2'b00};
  localparam logic [11:0] A_STAT = {wwd_pkg::IDX_STATUS, 2'b00};
  localparam logic [11:0] A_KEY = {wwd_pkg::IDX_PROT, 2'b00};
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] ticks;
  } wwd_row_t;
  logic core_clk, reset, debug_halt, clear_instr, reset_req, err;
  logic [7:0] fuse_ctrl;
  logic [31:0] q;
  wwd_pkg::wwd_apb_req_t apb_req;
  wwd_pkg::wwd_apb_rsp_t apb_rsp;
  int num_errors, cmp_count;
  // Window code set but no clear yet: plain period time-out; reserved code saturates
  wwd_row_t rows [5] = '{'{8'h01, 16'h0008}, '{8'h02, 16'h0010}, '{8'h03, 16'h0020},
                         '{8'h11, 16'h0008}, '{8'h0C, 16'h2000}};

  wwd_watchdog #(.TICK_DIV(DIV), .PROT_KEY(KEY)) wwd_watchdog_inst (
    .i_core_clk(core_clk), .i_reset(reset), .i_apb(apb_req), .i_clear_instr(clear_instr),
    .i_debug_halt(debug_halt), .i_fuse_ctrl(fuse_ctrl), .o_apb(apb_rsp), .o_reset_req(reset_req));
  wwd_core_model #(.KEY(KEY)) wwd_core_model_inst (
    .i_core_clk(core_clk), .i_apb(apb_rsp), .o_apb(apb_req), .o_clear_instr(clear_instr));

  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic hung;
    wwd_core_model_inst.xfer(wr, a, d, q, err, hung);
    check(!hung, "bus hang");
    if (hung) complete_run();
  endtask : bus

  task automatic prot(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, A_KEY, {24'h0, KEY});
    bus(1'b1, a, d);
  endtask : prot

  task automatic do_reset(input logic [7:0] fuse);
    @(posedge core_clk);
    reset <= 1'b1;
    fuse_ctrl <= fuse;
    debug_halt <= 1'b0;
    repeat (16) @(posedge core_clk);
    check(reset_req === 1'b0 && apb_rsp.pready === 1'b0, "outputs not low in reset");
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  task automatic wait_req(input int lo, input int hi);
    int n;
    n = 0;
    while (reset_req !== 1'b1 && n <= hi) begin
      @(posedge core_clk);
      n++;
    end
    check(n >= lo && n <= hi, "reset request timing");
    if (n > hi) complete_run();
  endtask : wait_req

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    reset = 1'b1;
    fuse_ctrl = 8'h00;
    debug_halt = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    for (int i = 0; i < 5; i++) begin
      do_reset(8'h00);
      prot(A_CTRL, {24'h0, rows[i].ctrl});
      wait_req(int'(rows[i].ticks) * DIV, int'(rows[i].ticks) * DIV + 16);
      repeat (10) @(posedge core_clk);
      check(reset_req === 1'b1, "request dropped");
    end
    // Unlock expiry, plain writes, unmapped index, write during sync
    do_reset(8'h00);
    bus(1'b1, A_KEY, {24'h0, KEY});
    repeat (4) bus(1'b0, A_STAT, 32'h0);
    bus(1'b1, A_CTRL, 32'h01);
    bus(1'b0, A_CTRL, 32'h0);
    check(q[7:0] === 8'h00, "write after unlock expiry");
    bus(1'b1, A_CTRL, 32'h01);
    bus(1'b0, A_CTRL, 32'h0);
    check(q[7:0] === 8'h00, "unprotected write");
    bus(1'b0, 12'h00C, 32'h0);
    check(err === 1'b1 && q === 32'h0, "unmapped access");
    bus(1'b1, A_KEY, {24'h0, KEY});
    bus(1'b1, A_CTRL, 32'h01);
    bus(1'b1, A_CTRL, 32'h02);
    bus(1'b0, A_CTRL, 32'h0);
    check(q[7:0] === 8'h01, "write during sync");
    // Window mode: clears in the open slot keep it alive, an early one trips it
    do_reset(8'h00);
    wwd_core_model_inst.clear_pulse();
    bus(1'b0, A_STAT, 32'h0);
    check(q[0] === 1'b0, "clear taken while off");
    prot(A_CTRL, 32'h22);
    repeat (20) @(posedge core_clk);
    repeat (6) begin
      wwd_core_model_inst.clear_pulse();
      bus(1'b0, A_STAT, 32'h0);
      check(q[0] === 1'b1, "clear sync flag");
      repeat (95) @(posedge core_clk);
    end
    check(reset_req === 1'b0, "timely clears tripped");
    wwd_core_model_inst.clear_pulse();
    wwd_core_model_inst.clear_pulse();
    repeat (20) @(posedge core_clk);
    check(reset_req === 1'b0, "clear during sync not ignored");
    wwd_core_model_inst.clear_pulse();
    wait_req(1, 24);
    // No clear in the open slot: late trip after closed plus open periods
    do_reset(8'h00);
    prot(A_CTRL, 32'h11);
    repeat (20) @(posedge core_clk);
    wwd_core_model_inst.clear_pulse();
    wait_req(64, 88);
    // Fuse load locks; lock only cleared in debug
    do_reset(8'h03);
    bus(1'b0, A_CTRL, 32'h0);
    check(q[7:0] === 8'h03, "fuse image");
    bus(1'b0, A_STAT, 32'h0);
    check(q[7] === 1'b1, "fuse lock");
    prot(A_CTRL, 32'h01);
    prot(A_STAT, 32'h0);
    bus(1'b0, A_CTRL, 32'h0);
    check(q[7:0] === 8'h03, "locked control changed");
    bus(1'b0, A_STAT, 32'h0);
    check(q[7] === 1'b1, "lock cleared outside debug");
    @(posedge core_clk);
    debug_halt <= 1'b1;
    prot(A_STAT, 32'h0);
    bus(1'b0, A_STAT, 32'h0);
    check(q[7] === 1'b0, "lock not cleared in debug");
    repeat (200) @(posedge core_clk);
    check(reset_req === 1'b0, "count ran in debug halt");
    debug_halt <= 1'b0;
    wait_req(124, 144);
    complete_run();
  end
endmodule : wwd_watchdog_tb
